//--- verilog/etc_regs.svh
`ifndef ETC_REGS_SVH
`define ETC_REGS_SVH

// Time base and figures for the capture counters.
`define ETC_CLK_PERIOD_NS     25
`define ETC_TIME_W            32
`define ETC_COUNT_W           16
`define ETC_DELAY_W           16
`define ETC_RATE_W            24
`define ETC_QERR_W            8
// Reset values.
`define ETC_TIME_RST          32'h0000_0000
`define ETC_COUNT_RST         16'h0000
`define ETC_RATE_RST          24'h00_0000
// Quantization error of one clock period, in nanoseconds.
`define ETC_QERR_NS           8'h19

`endif

//--- verilog/etc_pkg.sv
package etc_pkg;

    // Reference timescale in which mark times are expressed.
    typedef enum logic [2:0] {
        ETC_TS_UTC,
        ETC_TS_GPS,
        ETC_TS_GLONASS,
        ETC_TS_BEIDOU,
        ETC_TS_GALILEO,
        ETC_TS_LOCAL
    } etc_timescale_e;

    // Configuration from the host.
    typedef struct packed {
        logic           report_enable;
        etc_timescale_e timescale;
        logic [23:0]    meas_rate_cycles;
        logic [15:0]    cable_delay;
        logic [15:0]    user_delay;
    } etc_cfg_s;

    // One timemark report.
    typedef struct packed {
        logic [31:0]    rise_time;
        logic [31:0]    fall_time;
        logic           new_rise;
        logic           new_fall;
        etc_timescale_e timescale;
        logic           valid;
        logic [15:0]    mark_count;
        logic [7:0]     qerr;
    } etc_report_s;

endpackage : etc_pkg

//--- verilog/etc_timemark.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_regs.svh"

module etc_timemark (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 event_in,
    input  wire logic                 time_valid,
    input  wire logic [31:0]          time_now,
    input  wire etc_pkg::etc_cfg_s    cfg,
    output logic                      report_valid,
    output etc_pkg::etc_report_s      report
);

    // ----------------------------------------------------------------
    // Input synchroniser and edge detection
    // ----------------------------------------------------------------

    // Two flops ahead of any logic; the third stage gives the edge history.
    logic sync_1;
    logic sync_2;
    logic sync_3;
    logic next_sync_1;
    logic next_sync_2;
    logic next_sync_3;
    logic rise_seen;
    logic fall_seen;

    always_comb begin
        next_sync_1 = event_in;
        next_sync_2 = sync_1;
        next_sync_3 = sync_2;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_3 <= 1'b0;
        end else begin
            sync_1 <= next_sync_1;
            sync_2 <= next_sync_2;
            sync_3 <= next_sync_3;
        end
    end

    assign rise_seen = sync_2 & ~sync_3;
    assign fall_seen = ~sync_2 & sync_3;

    // ----------------------------------------------------------------
    // Epoch timer
    // ----------------------------------------------------------------

    // A zero rate is treated as one cycle so the timer never stalls.
    logic [23:0] epoch_cnt;
    logic [23:0] next_epoch_cnt;
    logic        epoch_tick;

    assign epoch_tick = (epoch_cnt == 24'h00_0000);

    always_comb begin
        if (epoch_tick) begin
            next_epoch_cnt = (cfg.meas_rate_cycles == 24'h00_0000) ? 24'h00_0000
                           : cfg.meas_rate_cycles - 24'h00_0001;
        end else begin
            next_epoch_cnt = epoch_cnt - 24'h00_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            epoch_cnt <= `ETC_RATE_RST;
        end else begin
            epoch_cnt <= next_epoch_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Capture and report
    // ----------------------------------------------------------------

    // The delays are subtracted so the mark lands at the antenna instant;
    // the synchroniser lag of two cycles is not taken out and is larger than the one-period quantization error.
    logic [31:0] corr_time;
    assign corr_time = time_now - {16'h0000, cfg.cable_delay}
                                - {16'h0000, cfg.user_delay};

    logic [31:0]          rise_time;
    logic [31:0]          fall_time;
    logic                 new_rise;
    logic                 new_fall;
    logic [15:0]          mark_count;
    logic                 mark_valid;
    logic                 next_report_valid;
    etc_pkg::etc_report_s next_report;
    logic [31:0]          next_rise_time;
    logic [31:0]          next_fall_time;
    logic                 next_new_rise;
    logic                 next_new_fall;
    logic [15:0]          next_mark_count;
    logic                 next_mark_valid;

    // Capture never waits for the host; a report only clears flags.
    always_comb begin
        next_rise_time    = rise_time;
        next_fall_time    = fall_time;
        next_new_rise     = new_rise;
        next_new_fall     = new_fall;
        next_mark_count   = mark_count;
        next_mark_valid   = mark_valid;
        next_report_valid = 1'b0;
        next_report       = report;
        if (epoch_tick && (cfg.report_enable || new_rise || new_fall)) begin
            next_report_valid    = 1'b1;
            next_report.rise_time  = rise_time;
            next_report.fall_time  = fall_time;
            next_report.new_rise   = new_rise;
            next_report.new_fall   = new_fall;
            next_report.timescale  = cfg.timescale;
            next_report.valid      = mark_valid;
            next_report.mark_count = mark_count;
            next_report.qerr       = `ETC_QERR_NS;
            next_new_rise        = 1'b0;
            next_new_fall        = 1'b0;
        end
        // An edge in the report cycle wins over the flag clear.
        if (rise_seen) begin
            next_rise_time  = corr_time;
            next_new_rise   = 1'b1;
            next_mark_count = mark_count + 16'h0001;
            next_mark_valid = time_valid;
        end
        if (fall_seen) begin
            next_fall_time  = corr_time;
            next_new_fall   = 1'b1;
            next_mark_count = mark_count + 16'h0001;
            next_mark_valid = time_valid;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_time    <= `ETC_TIME_RST;
            fall_time    <= `ETC_TIME_RST;
            new_rise     <= 1'b0;
            new_fall     <= 1'b0;
            mark_count   <= `ETC_COUNT_RST;
            mark_valid   <= 1'b0;
            report_valid <= 1'b0;
            report       <= '0;
        end else begin
            rise_time    <= next_rise_time;
            fall_time    <= next_fall_time;
            new_rise     <= next_new_rise;
            new_fall     <= next_new_fall;
            mark_count   <= next_mark_count;
            mark_valid   <= next_mark_valid;
            report_valid <= next_report_valid;
            report       <= next_report;
        end
    end

endmodule // etc_timemark
`default_nettype wire

//--- sim/etc_timemark_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_regs.svh"
// ----
// Report checks
// ----
module etc_timemark_props (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 event_in,
    input wire logic                 time_valid,
    input wire logic [31:0]          time_now,
    input wire etc_pkg::etc_cfg_s    cfg,
    input wire logic                 report_valid,
    input wire etc_pkg::etc_report_s report
);
    localparam int LIM = 40;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    hold_a: assert property ($changed(report) |-> report_valid)
        else $error("report moved alone");
    qerr_a: assert property (report_valid |-> report.qerr == `ETC_QERR_NS)
        else $error("bad qerr");
    spacing_a: assert property (report_valid && cfg.meas_rate_cycles > 24'h8 |=>
        (!report_valid) [*8]) else $error("reports too close");
    periodic_a: assert property (report_valid && cfg.report_enable |->
        ##[1:LIM] (report_valid || !cfg.report_enable)) else $error("report missing");
    rise_a: assert property ($rose(event_in) |->
        ##[1:LIM] (report_valid && report.new_rise)) else $error("rise lost");
    fall_a: assert property ($fell(event_in) |->
        ##[1:LIM] (report_valid && report.new_fall)) else $error("fall lost");
    quiet_a: assert property (report_valid && !$past(cfg.report_enable) |->
        report.new_rise || report.new_fall) else $error("report without cause");
    scale_a: assert property (report_valid && cfg.timescale == $past(cfg.timescale, 8) |->
        report.timescale == cfg.timescale) else $error("bad scale");
    cover property (report_valid && report.new_rise);
    cover property (report_valid && report.new_fall);
    cover property (report_valid && !report.new_rise && !report.new_fall);
endmodule // etc_timemark_props

bind etc_timemark etc_timemark_props i_props (.clk(clk), .rst_b(rst_b),
    .event_in(event_in), .time_valid(time_valid), .time_now(time_now), .cfg(cfg),
    .report_valid(report_valid), .report(report));
`default_nettype wire

//--- sim/etc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// External pulse source
// ----
module etc_pulse_src (
    input  wire logic clk,
    input  wire logic level,
    output logic      event_in
);
    // The pin moves off the clock edge, as an unsynchronised source would.
    initial event_in = 1'b0;
    always @(posedge clk) event_in <= #2 level;
endmodule // etc_pulse_src
`default_nettype wire

//--- sim/etc_timemark_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_regs.svh"
// ----
// Bench
// ----
module etc_timemark_test;
    logic                 clk;
    logic                 rst_b;
    logic                 level;
    logic                 event_in;
    logic                 time_valid;
    logic [31:0]          time_now;
    etc_pkg::etc_cfg_s    cfg;
    logic                 report_valid;
    etc_pkg::etc_report_s report;
    int                   error_cnt;
    int                   checked;
    int                   gap;
    etc_pulse_src i_src (.clk(clk), .level(level), .event_in(event_in));
    etc_timemark i_dut (.clk(clk), .rst_b(rst_b), .event_in(event_in), .time_valid(time_valid),
        .time_now(time_now), .cfg(cfg), .report_valid(report_valid), .report(report));
    // Clock and a receiver time that steps once a cycle.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) time_now <= #2 time_now + 32'h1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait for a report pulse; gap is the cycles it took.
    task automatic wait_rpt();
        gap = 0;
        do begin
            @(posedge clk);
            #1;
            gap++;
        end while (report_valid !== 1'b1 && gap < 60);
        if (report_valid !== 1'b1) begin
            check(report_valid, 1'b1);
            end_of_test();
        end
    endtask
    task automatic t_period();
        wait_rpt();
        wait_rpt();
        check(gap, 32'h18);
        check(report.qerr, `ETC_QERR_NS);
        check({report.new_rise, report.new_fall, report.mark_count}, 32'h0);
        $display("period test done");
    endtask
    // Edges are launched just after a report so all land in one epoch.
    task automatic t_edges();
        logic [31:0] vf;
        logic [31:0] vr;
        wait_rpt();
        #1;
        level = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        level = 1'b0;
        // Read the time base after its own update settles, not in the same step.
        #1;
        vf = time_now;
        repeat (4) @(posedge clk);
        #2;
        level = 1'b1;
        #1;
        vr = time_now;
        wait_rpt();
        check(report.rise_time, vr + 32'h3 - cfg.cable_delay - cfg.user_delay);
        check(report.fall_time, vf + 32'h3 - cfg.cable_delay - cfg.user_delay);
        check({report.new_rise, report.new_fall, report.valid}, 32'h7);
        check(report.mark_count, 32'h3);
        wait_rpt();
        check({report.new_rise, report.new_fall}, 32'h0);
        #1;
        cfg.report_enable = 1'b0;
        time_valid = 1'b0;
        level = 1'b0;
        wait_rpt();
        check({report.new_rise, report.new_fall, report.valid}, 32'h2);
        check(report.mark_count, 32'h4);
        repeat (60) begin
            @(posedge clk);
            #1;
            check(report_valid, 1'b0);
        end
        $display("edge test done");
    endtask
    task automatic t_scale();
        for (int s = 0; s < 6; s++) begin
            #1;
            cfg.report_enable = 1'b1;
            cfg.timescale = etc_pkg::etc_timescale_e'(s);
            wait_rpt();
            wait_rpt();
            check(report.timescale, s);
        end
        $display("scale test done");
    endtask
    initial begin
        error_cnt = 0;
        checked = 0;
        rst_b = 1'b0;
        level = 1'b0;
        time_valid = 1'b1;
        time_now = 32'h0;
        cfg = '{1'b1, etc_pkg::ETC_TS_GPS, 24'h000018, 16'h0003, 16'h0005};
        repeat (5) @(posedge clk);
        #2;
        rst_b = 1'b1;
        t_period();
        t_edges();
        t_scale();
        end_of_test();
    end
endmodule // etc_timemark_test
`default_nettype wire
